// File: logic/timer_wave_pkg.sv
`default_nettype none
package timer_wave_pkg;
	// **********************************************
	// Register map, byte addresses
	// **********************************************
	localparam logic [7:0] CMD_OFS  = 8'h60;
	localparam logic [7:0] CFG_OFS  = 8'h64;
	localparam logic [7:0] STAT_OFS = 8'h70;
	localparam logic [7:0] CNT_OFS  = 8'h80;
	localparam logic [7:0] CMPA_OFS = 8'h84;
	localparam logic [7:0] CMPB_OFS = 8'h88;
	localparam logic [7:0] CMPC_OFS = 8'h8C;
	localparam logic [7:0] SYNC_OFS = 8'hC0;
	// Command bits
	localparam int CMD_RST     = 0;
	localparam int CMD_CLK_ON  = 1;
	localparam int CMD_CLK_OFF = 2;
	localparam int CMD_TRIG    = 3;
	// Configuration fields, low bit of each
	localparam int CFG_CLK     = 0;
	localparam int CFG_INV     = 3;
	localparam int CFG_BURST   = 4;
	localparam int CFG_HALT    = 6;
	localparam int CFG_GATEOFF = 7;
	localparam int CFG_EDGE    = 8;
	localparam int CFG_SRC     = 10;
	localparam int CFG_EVRST   = 12;
	localparam int CFG_CRST    = 14;
	localparam int CFG_WAVE    = 15;
	localparam int CFG_A_MA    = 16;
	localparam int CFG_A_MC    = 18;
	localparam int CFG_A_EV    = 20;
	localparam int CFG_A_SW    = 22;
	localparam int CFG_B_MB    = 24;
	localparam int CFG_B_MC    = 26;
	localparam int CFG_B_EV    = 28;
	localparam int CFG_B_SW    = 30;
	// Status bits
	localparam int ST_OVF   = 0;
	localparam int ST_MA    = 2;
	localparam int ST_MB    = 3;
	localparam int ST_MC    = 4;
	localparam int ST_EVT   = 7;
	localparam int ST_CLK   = 8;
	localparam int ST_MIR_A = 9;
	localparam int ST_MIR_B = 10;
	// Reset values and counter limits
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	// Prescaler taps for core clock divided by 2, 8, 32, 128, 1024
	localparam int PRESC_W = 10;
	localparam int DIV_TAP [5] = '{0, 2, 4, 6, 9};
	localparam logic [2:0] CLK_EXT0 = 3'h5;
	localparam logic [1:0] SRC_LINE_B = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00, ACT_SET = 2'b01, ACT_CLEAR = 2'b10, ACT_TOGGLE = 2'b11
	} line_action_t;
	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10, EDGE_BOTH = 2'b11
	} edge_choice_t;
	typedef enum logic {RD_IDLE = 1'b0, RD_RESP = 1'b1} rd_state_t;
endpackage : timer_wave_pkg
`default_nettype wire

// File: logic/timer_wave_channel.sv
// Behaviour
// - Configuration wave bit set makes line A an output; line B output or input.
// - Line A acts on soft trigger, external event, match A and match C.
// - Line B output acts on soft trigger, event, match B and match C.
// - Action code 00 none, 01 set, 10 clear, 11 toggle.
// - One action per line per cycle: soft, event, match C, then A or B.
// - Match-C restart bit makes a C match reset and start the counter.
// - Match-C halt stops the counter; only a later trigger restarts it.
// - Match-C gate-off stops counter and clock; only clock-on re-enables it.
// - A trigger zeroes and starts the counter on next tick, clock enabled only.
// - Command bit 1 enables clock unless bit 2 set; bit 2 disables.
// - Command bit 0 resets every channel register.
// - Command bit 3 raises a soft trigger.
// - Clock choice picks core clock /2../1024 or external clocks 0..2.
// - Invert bit makes the counter step on the falling edge.
// - Burst field ANDs the selected clock with an external clock.
// - Edge field picks none, rising, falling or both edges.
// - A detected event sets its flag, may restart, and drives line actions.
// - Source field picks line B or external clocks 0..2.
// - Line B source means line B is input; its actions and compare B ignored.
// - With event restart off an event only sets its flag and drives line actions.
// - Five event sources: event, overflow, matches A, B and C.
// - A sync register write issues a soft trigger.
// - Period is compare C plus one with C restart, else full range.
// - Match, overflow and event flags set on events, cleared by status read.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_wave_channel #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	// Write response
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// Read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// External clocks and lines
	input  wire logic              ext_clock_0,
	input  wire logic              ext_clock_1,
	input  wire logic              ext_clock_2,
	input  wire logic              output_line_a_i,
	output var  logic              output_line_a_o,
	output var  logic              output_line_a_oe,
	input  wire logic              output_line_b_i,
	output var  logic              output_line_b_o,
	output var  logic              output_line_b_oe
);
	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge

	// Applies one action code to a line level
	function automatic logic apply(input logic cur, input logic [1:0] act);
		case (timer_wave_pkg::line_action_t'(act))
			timer_wave_pkg::ACT_SET:    return 1'b1;
			timer_wave_pkg::ACT_CLEAR:  return 1'b0;
			timer_wave_pkg::ACT_TOGGLE: return ~cur;
			default:                    return cur;
		endcase
	endfunction : apply

	// ****************************************************
	// Write channel
	// ****************************************************
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              aw_full_q;
	logic              w_full_q;
	logic              wr_hit;
	logic              do_wr;
	logic [7:0]        wofs;
	assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign wofs  = 8'(waddr_q);

	// Address and data are latched separately so either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= timer_wave_pkg::RESP_OKAY;
			waddr_q       <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_q       <= s_axi_awaddr;
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? timer_wave_pkg::RESP_OKAY
					: timer_wave_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	logic cmd_wr;
	logic sw_trig;
	logic ch_rst;
	assign wr_hit = wofs == timer_wave_pkg::CMD_OFS || wofs == timer_wave_pkg::CFG_OFS
		|| wofs == timer_wave_pkg::CMPA_OFS || wofs == timer_wave_pkg::CMPB_OFS
		|| wofs == timer_wave_pkg::CMPC_OFS || wofs == timer_wave_pkg::SYNC_OFS;
	assign cmd_wr = do_wr && wofs == timer_wave_pkg::CMD_OFS && wstrb_q[0];
	// Soft trigger from the command bit or a sync write
	assign sw_trig = (cmd_wr && wdata_q[timer_wave_pkg::CMD_TRIG])
		|| (do_wr && wofs == timer_wave_pkg::SYNC_OFS);
	// Channel reset leaves the bus handshake alone
	assign ch_rst = !aresetn || (cmd_wr && wdata_q[timer_wave_pkg::CMD_RST]);

	// ****************************************************
	// Configuration and compare registers
	// ****************************************************
	logic [31:0] cfg_q;
	logic [15:0] cmp_a_q;
	logic [15:0] cmp_b_q;
	logic [15:0] cmp_c_q;
	always_ff @(posedge aclk) begin
		if (ch_rst) begin
			cfg_q   <= timer_wave_pkg::CFG_RESET;
			cmp_a_q <= timer_wave_pkg::CNT_ZERO;
			cmp_b_q <= timer_wave_pkg::CNT_ZERO;
			cmp_c_q <= timer_wave_pkg::CNT_ZERO;
		end else if (do_wr) begin
			case (wofs)
				timer_wave_pkg::CFG_OFS:  cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
				timer_wave_pkg::CMPA_OFS: cmp_a_q <= 16'(merge({16'h0000, cmp_a_q}, wdata_q, wstrb_q));
				timer_wave_pkg::CMPB_OFS: cmp_b_q <= 16'(merge({16'h0000, cmp_b_q}, wdata_q, wstrb_q));
				timer_wave_pkg::CMPC_OFS: cmp_c_q <= 16'(merge({16'h0000, cmp_c_q}, wdata_q, wstrb_q));
				default: ;
			endcase
		end
	end

	logic       wave;
	logic       single;
	logic [2:0] clk_sel;
	logic [1:0] burst;
	logic [1:0] src;
	assign wave    = cfg_q[timer_wave_pkg::CFG_WAVE];
	assign clk_sel = cfg_q[timer_wave_pkg::CFG_CLK +: 3];
	assign burst   = cfg_q[timer_wave_pkg::CFG_BURST +: 2];
	assign src     = cfg_q[timer_wave_pkg::CFG_SRC +: 2];
	assign single  = src == timer_wave_pkg::SRC_LINE_B;

	// ****************************************************
	// Counter clock: prescaler, select, burst, invert
	// ****************************************************
	logic [timer_wave_pkg::PRESC_W-1:0] presc_q;
	logic [2:0] ext_clk;
	logic       base_lvl;
	logic       gate_lvl;
	logic       clk_lvl;
	logic       clk_prev_q;
	logic       tick;
	assign ext_clk = {ext_clock_2, ext_clock_1, ext_clock_0};

	// Divided core clocks are prescaler bits, so every choice is edge detected alike
	always_comb begin
		if (clk_sel < timer_wave_pkg::CLK_EXT0)
			base_lvl = presc_q[timer_wave_pkg::DIV_TAP[clk_sel]];
		else
			base_lvl = ext_clk[2'(clk_sel - timer_wave_pkg::CLK_EXT0)];
		gate_lvl = (burst == 2'b00) ? 1'b1 : ext_clk[2'(burst - 2'b01)];
		clk_lvl  = (base_lvl & gate_lvl) ^ cfg_q[timer_wave_pkg::CFG_INV];
	end

	always_ff @(posedge aclk) begin
		if (ch_rst) begin
			presc_q    <= '0;
			clk_prev_q <= 1'b0;
		end else begin
			presc_q    <= presc_q + 1'b1;
			clk_prev_q <= clk_lvl;
		end
	end
	assign tick = clk_lvl & ~clk_prev_q;

	// ****************************************************
	// External event detection
	// ****************************************************
	logic src_lvl;
	logic src_prev_q;
	logic evt_hit;
	assign src_lvl = single ? output_line_b_i : ext_clk[2'(src - 2'b01)];
	always_ff @(posedge aclk) begin
		if (ch_rst) src_prev_q <= 1'b0;
		else src_prev_q <= src_lvl;
	end
	always_comb begin
		case (timer_wave_pkg::edge_choice_t'(cfg_q[timer_wave_pkg::CFG_EDGE +: 2]))
			timer_wave_pkg::EDGE_RISE: evt_hit = src_lvl & ~src_prev_q;
			timer_wave_pkg::EDGE_FALL: evt_hit = ~src_lvl & src_prev_q;
			timer_wave_pkg::EDGE_BOTH: evt_hit = src_lvl ^ src_prev_q;
			default:                   evt_hit = 1'b0;
		endcase
	end

	// ****************************************************
	// Counter, triggers, clock enable
	// ****************************************************
	logic [15:0] cnt_q;
	logic        run_q;
	logic        pend_q;
	logic        upd_q;
	logic        clk_en_q;
	logic        match_a;
	logic        match_b;
	logic        match_c;
	logic        stop_now;
	logic        trig_req;
	logic        clk_off;
	logic        clk_on;
	logic        step;
	logic        ovf;
	// Matches are judged once per counter change, not while it sits still
	assign match_a  = upd_q && cnt_q == cmp_a_q;
	assign match_b  = upd_q && cnt_q == cmp_b_q && !single;
	assign match_c  = upd_q && cnt_q == cmp_c_q;
	assign stop_now = match_c && (cfg_q[timer_wave_pkg::CFG_HALT]
		|| cfg_q[timer_wave_pkg::CFG_GATEOFF]);
	// A C match that also halts raises no trigger
	assign trig_req = sw_trig || (evt_hit && cfg_q[timer_wave_pkg::CFG_EVRST])
		|| (match_c && cfg_q[timer_wave_pkg::CFG_CRST] && !stop_now);
	assign clk_off = (cmd_wr && wdata_q[timer_wave_pkg::CMD_CLK_OFF])
		|| (match_c && cfg_q[timer_wave_pkg::CFG_GATEOFF]);
	assign clk_on  = cmd_wr && wdata_q[timer_wave_pkg::CMD_CLK_ON];
	assign step    = tick && clk_en_q;
	assign ovf     = step && run_q && !pend_q && cnt_q == timer_wave_pkg::CNT_MAX;

	// Disable beats enable when both arrive together
	always_ff @(posedge aclk) begin
		if (ch_rst) clk_en_q <= 1'b0;
		else if (clk_off) clk_en_q <= 1'b0;
		else if (clk_on) clk_en_q <= 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (ch_rst) begin
			cnt_q  <= timer_wave_pkg::CNT_ZERO;
			run_q  <= 1'b0;
			pend_q <= 1'b0;
			upd_q  <= 1'b0;
		end else begin
			upd_q <= step && (pend_q || run_q);
			if (step && pend_q) begin
				cnt_q <= timer_wave_pkg::CNT_ZERO;
				run_q <= 1'b1;
			end else if (step && run_q) begin
				cnt_q <= cnt_q + 16'h0001;
			end
			if (stop_now) run_q <= 1'b0;
			// Triggers only count while the clock is enabled
			if (clk_off) pend_q <= 1'b0;
			else if (step && pend_q) pend_q <= trig_req;
			else if (trig_req && clk_en_q) pend_q <= 1'b1;
		end
	end

	// ****************************************************
	// Status flags, cleared by a status read
	// ****************************************************
	logic       rd_clr;
	logic [4:0] flag_q;
	logic [4:0] flag_set;
	assign flag_set = {evt_hit, match_c, match_b, match_a, ovf};
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : flags
			// A set in the read cycle survives the clear
			always_ff @(posedge aclk) begin
				if (ch_rst) flag_q[g] <= 1'b0;
				else flag_q[g] <= flag_set[g] | (flag_q[g] & ~rd_clr);
			end
		end
	endgenerate

	// ****************************************************
	// Output lines
	// ****************************************************
	logic [1:0] act_a;
	logic [1:0] act_b;
	// Highest priority event present with a non-empty action wins
	always_comb begin
		act_a = timer_wave_pkg::ACT_NONE;
		act_b = timer_wave_pkg::ACT_NONE;
		if (match_a) act_a = cfg_q[timer_wave_pkg::CFG_A_MA +: 2];
		if (match_c && cfg_q[timer_wave_pkg::CFG_A_MC +: 2] != 2'b00)
			act_a = cfg_q[timer_wave_pkg::CFG_A_MC +: 2];
		if (evt_hit && cfg_q[timer_wave_pkg::CFG_A_EV +: 2] != 2'b00)
			act_a = cfg_q[timer_wave_pkg::CFG_A_EV +: 2];
		if (sw_trig && cfg_q[timer_wave_pkg::CFG_A_SW +: 2] != 2'b00)
			act_a = cfg_q[timer_wave_pkg::CFG_A_SW +: 2];
		if (match_b) act_b = cfg_q[timer_wave_pkg::CFG_B_MB +: 2];
		if (match_c && cfg_q[timer_wave_pkg::CFG_B_MC +: 2] != 2'b00)
			act_b = cfg_q[timer_wave_pkg::CFG_B_MC +: 2];
		if (evt_hit && cfg_q[timer_wave_pkg::CFG_B_EV +: 2] != 2'b00)
			act_b = cfg_q[timer_wave_pkg::CFG_B_EV +: 2];
		if (sw_trig && cfg_q[timer_wave_pkg::CFG_B_SW +: 2] != 2'b00)
			act_b = cfg_q[timer_wave_pkg::CFG_B_SW +: 2];
	end

	always_ff @(posedge aclk) begin
		if (ch_rst) begin
			output_line_a_o  <= 1'b0;
			output_line_a_oe <= 1'b0;
			output_line_b_o  <= 1'b0;
			output_line_b_oe <= 1'b0;
		end else begin
			output_line_a_oe <= wave;
			output_line_b_oe <= wave && !single;
			if (wave) output_line_a_o <= apply(output_line_a_o, act_a);
			if (wave && !single) output_line_b_o <= apply(output_line_b_o, act_b);
		end
	end

	// ****************************************************
	// Read channel
	// ****************************************************
	timer_wave_pkg::rd_state_t rd_q;
	logic [7:0]  rofs;
	logic [31:0] rd_word;
	logic        rd_hit;
	assign rofs   = 8'(s_axi_araddr);
	assign rd_clr = s_axi_arvalid && s_axi_arready && rofs == timer_wave_pkg::STAT_OFS;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (rofs)
			timer_wave_pkg::CMD_OFS, timer_wave_pkg::SYNC_OFS: rd_word = 32'h0000_0000;
			timer_wave_pkg::CFG_OFS:  rd_word = cfg_q;
			timer_wave_pkg::CNT_OFS:  rd_word = {16'h0000, cnt_q};
			timer_wave_pkg::CMPA_OFS: rd_word = {16'h0000, cmp_a_q};
			timer_wave_pkg::CMPB_OFS: rd_word = {16'h0000, cmp_b_q};
			timer_wave_pkg::CMPC_OFS: rd_word = {16'h0000, cmp_c_q};
			timer_wave_pkg::STAT_OFS: begin
				rd_word[timer_wave_pkg::ST_OVF]   = flag_q[0];
				rd_word[timer_wave_pkg::ST_MA]    = flag_q[1];
				rd_word[timer_wave_pkg::ST_MB]    = flag_q[2];
				rd_word[timer_wave_pkg::ST_MC]    = flag_q[3];
				rd_word[timer_wave_pkg::ST_EVT]   = flag_q[4];
				rd_word[timer_wave_pkg::ST_CLK]   = clk_en_q;
				rd_word[timer_wave_pkg::ST_MIR_A] = output_line_a_i;
				rd_word[timer_wave_pkg::ST_MIR_B] = output_line_b_i;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q          <= timer_wave_pkg::RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= timer_wave_pkg::RESP_OKAY;
		end else begin
			case (rd_q)
				timer_wave_pkg::RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_q          <= timer_wave_pkg::RD_RESP;
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= rd_word;
						s_axi_rresp   <= rd_hit ? timer_wave_pkg::RESP_OKAY
							: timer_wave_pkg::RESP_SLVERR;
					end
				end
				timer_wave_pkg::RD_RESP: begin
					if (s_axi_rready) begin
						rd_q          <= timer_wave_pkg::RD_IDLE;
						s_axi_arready <= 1'b1;
						s_axi_rvalid  <= 1'b0;
					end
				end
				default: rd_q <= timer_wave_pkg::RD_IDLE;
			endcase
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (ch_rst);
	sequence soft_raised;
		sw_trig && clk_en_q && !clk_off;
	endsequence
	sequence restart_tick;
		step && pend_q;
	endsequence
	clock_on_a: assert property (clk_on && !clk_off |=> clk_en_q)
		else $error("clock enable command ignored");
	gate_off_a: assert property (clk_off |=> !clk_en_q ##1 !pend_q || clk_en_q)
		else $error("clock still enabled after gate off");
	halt_a: assert property (stop_now |=> !run_q && cnt_q == $past(cnt_q))
		else $error("counter kept running after halt");
	soft_pend_a: assert property (soft_raised |=> pend_q)
		else $error("soft trigger lost");
	restart_a: assert property (restart_tick |=> cnt_q == 16'h0000 && run_q ##0 upd_q)
		else $error("trigger did not zero the counter");
	count_step_a: assert property (step && run_q && !pend_q && !stop_now
		|=> cnt_q == 16'($past(cnt_q) + 16'h0001))
		else $error("counter did not advance by one");
	line_a_dir_a: assert property (wave |=> output_line_a_oe)
		else $error("line A not driven in waveform mode");
	line_b_in_a: assert property (single |=> !output_line_b_oe)
		else $error("line B driven while it is the event input");
	soft_set_a: assert property (wave && sw_trig
		&& cfg_q[timer_wave_pkg::CFG_A_SW +: 2] == 2'b01 |=> output_line_a_o)
		else $error("soft trigger set on line A lost");
	flag_clear_a: assert property (rd_clr && flag_set == 5'h00 |=> flag_q == 5'h00)
		else $error("status flags not cleared by read");
	event_flag_a: assert property (evt_hit |=> flag_q[4])
		else $error("event flag not set");
endmodule : timer_wave_channel
`default_nettype wire

// File: tb/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Far side of the channel pins: event source and pulled-up line wires
module pin_partner (
	// Stimulus from the bench
	input  wire logic ev_req,
	// Line drivers of the channel
	input  wire logic a_o,
	input  wire logic a_oe,
	input  wire logic b_o,
	input  wire logic b_oe,
	// Pin levels seen by the channel
	output var  logic ext0,
	output var  logic a_i,
	output var  logic b_i
);
	// A released wire floats to the pull-up, never to the last driven value
	always_comb begin
		ext0 = ev_req;
		a_i = a_oe ? a_o : 1'h1;
		b_i = b_oe ? b_o : 1'h1;
	end
endmodule : pin_partner
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// **********************************************
	// Wiring, clock and bus tasks
	// **********************************************
	localparam logic [7:0] CMD = timer_wave_pkg::CMD_OFS;
	localparam logic [7:0] CFG = timer_wave_pkg::CFG_OFS;
	localparam logic [7:0] ST  = timer_wave_pkg::STAT_OFS;
	logic        aclk = 1'h0, aresetn = 1'h0, ev_req = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, a_o, a_oe, b_o, b_oe, ext0, a_i, b_i;
	logic [1:0]  bresp, rresp, resp;
	int          err_count = 0, checked = 0, cyc = 0;
	always #4 aclk = ~aclk;
	timer_wave_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_clock_0(ext0), .ext_clock_1(1'h0), .ext_clock_2(1'h0), .output_line_a_i(a_i),
		.output_line_a_o(a_o), .output_line_a_oe(a_oe), .output_line_b_i(b_i),
		.output_line_b_o(b_o), .output_line_b_oe(b_oe));
	pin_partner far (.ev_req(ev_req), .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe),
		.ext0(ext0), .a_i(a_i), .b_i(b_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Address and data may be taken at different edges, so each is released on its own
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		fork
			begin do @(posedge aclk); while (!awready); awvalid <= 1'h0; end
			begin do @(posedge aclk); while (!wready); wvalid <= 1'h0; end
		join
		while (!bvalid) @(posedge aclk);
		resp = bresp;
		bready <= 1'h0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		while (!rvalid) @(posedge aclk);
		rd = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask : rdr
	task automatic final_report();
		$display("compares %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			final_report();
		end
	end
	// **********************************************
	// Scenarios
	// **********************************************
	task automatic t_regs();
		rdr(CFG); chk(rd, 32'h0);
		wr(8'h90, 32'h1); chk(resp, timer_wave_pkg::RESP_SLVERR);
		rdr(8'h90); chk(resp, timer_wave_pkg::RESP_SLVERR);
		wr(CFG, 32'hA5A5C3C1); rdr(CFG); chk(rd, 32'hA5A5C3C1);
		wr(CMD, 32'h1); rdr(CFG); chk(rd, 32'h0);
		wr(CMD, 32'h6); rdr(ST); chk(rd[8], 1'h0);
		wr(CMD, 32'h2); rdr(ST); chk(rd[8], 1'h1);
		$display("registers done");
	endtask : t_regs
	task automatic t_lines();
		wr(CFG, 32'h40408400); wr(CMD, 32'h8); repeat (3) @(posedge aclk);
		chk({a_oe, a_o, b_oe, b_o}, 4'hF);
		wr(CFG, 32'hC0C08400); wr(CMD, 32'h8); repeat (3) @(posedge aclk);
		chk({a_oe, a_o, b_oe, b_o}, 4'hA);
		wr(timer_wave_pkg::SYNC_OFS, 32'h0); repeat (3) @(posedge aclk);
		chk({a_o, b_o}, 2'h3);
		wr(CFG, 32'h40808000); wr(CMD, 32'h8); repeat (3) @(posedge aclk);
		chk({a_oe, a_o, b_oe}, 3'h4);
		$display("lines done");
	endtask : t_lines
	task automatic t_count();
		wr(CMD, 32'h1); wr(CMD, 32'h2); wr(CMD, 32'h8); repeat (40) @(posedge aclk);
		rdr(timer_wave_pkg::CNT_OFS); chk(rd > 0 && rd < 32'h40, 1'h1);
		wr(timer_wave_pkg::CMPC_OFS, 32'h5); wr(CFG, 32'h40); wr(CMD, 32'h8);
		repeat (60) @(posedge aclk);
		rdr(timer_wave_pkg::CNT_OFS); chk(rd, 32'h5);
		rdr(ST); chk(rd[4], 1'h1);
		rdr(ST); chk(rd[4], 1'h0);
		wr(CFG, 32'h80); wr(CMD, 32'h8); repeat (60) @(posedge aclk);
		rdr(ST); chk(rd[8], 1'h0);
		$display("counter done");
	endtask : t_count
	// Compare C restart bounds the count; match B drives line B in dual mode
	task automatic t_period();
		wr(CMD, 32'h1); wr(CMD, 32'h2); wr(timer_wave_pkg::CMPB_OFS, 32'h3);
		wr(timer_wave_pkg::CMPC_OFS, 32'h5); wr(CFG, 32'h0100C400); wr(CMD, 32'h8);
		repeat (40) @(posedge aclk);
		rdr(timer_wave_pkg::CNT_OFS); chk(rd <= 32'h5, 1'h1);
		chk(b_o, 1'h1);
		$display("period done");
	endtask : t_period
	// Each pulse is one rising and one falling edge on external clock 0
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge aclk) ev_req <= 1'h1;
			repeat (2) @(posedge aclk);
			ev_req <= 1'h0;
			repeat (2) @(posedge aclk);
		end
	endtask : pulse
	task automatic t_event();
		wr(CMD, 32'h1); wr(CFG, 32'h00108500); wr(CMD, 32'h2);
		pulse(1);
		rdr(ST); chk(rd[7], 1'h1);
		chk(a_o, 1'h1);
		rdr(timer_wave_pkg::CNT_OFS); chk(rd, 32'h0);
		$display("event done");
	endtask : t_event
	// First edge restarts at zero, the next two count
	task automatic t_extclk();
		wr(CMD, 32'h1); wr(CMD, 32'h2); wr(CFG, 32'h5); wr(CMD, 32'h8);
		pulse(3);
		rdr(timer_wave_pkg::CNT_OFS); chk(rd, 32'h2);
		$display("external clock done");
	endtask : t_extclk
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_lines();
		t_count();
		t_period();
		t_event();
		t_extclk();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
